/* flash_launch_regs.svh */
// Purpose: offsets, field positions, reset values and command codes of the launch sequencer
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: availability masks hold one bit per command code 0x00..0x1F
`ifndef FLASH_LAUNCH_REGS_SVH
`define FLASH_LAUNCH_REGS_SVH

// register byte addresses
`define OFS_CLOCK_DIVIDER 8'h00
`define OFS_STATUS 8'h04
`define OFS_PARAM_INDEX 8'h08
`define OFS_PARAM_FIELD 8'h0C
`define OFS_PROTECTION 8'h10
`define OFS_MARGIN 8'h14

// clock divider register fields
`define DIV_LOADED_BIT 7
`define DIV_RESET 7'h00
// status register fields
`define STAT_COMPLETE_BIT 7
`define STAT_ACCESS_ERR_BIT 5
`define STAT_PROT_VIOL_BIT 4
`define STAT_VERIFY_FAIL_BIT 0
// protection register fields
`define PROT_LOW_DIS_BIT 0
`define PROT_HIGH_DIS_BIT 1
`define PROT_PF_OPEN_BIT 2
`define PROT_DF_OPEN_BIT 3
`define PROT_RESET 4'h0

// parameter field array
`define PARAM_COUNT 6
`define PARAM_RESET 16'h0000
// global address [22:16] that selects the data flash block
`define DF_BLOCK_GADDR 7'h10

// command codes
`define CMD_VERIFY_ALL 8'h01
`define CMD_VERIFY_BLOCK 8'h02
`define CMD_VERIFY_PF_SECTION 8'h03
`define CMD_READ_ONCE 8'h04
`define CMD_PROGRAM_PF 8'h06
`define CMD_PROGRAM_ONCE 8'h07
`define CMD_ERASE_ALL 8'h08
`define CMD_ERASE_BLOCK 8'h09
`define CMD_ERASE_PF_SECTOR 8'h0A
`define CMD_UNSECURE 8'h0B
`define CMD_BACKDOOR_KEY 8'h0C
`define CMD_USER_MARGIN 8'h0D
`define CMD_FIELD_MARGIN 8'h0E
`define CMD_VERIFY_DF_SECTION 8'h10
`define CMD_PROGRAM_DF 8'h11
`define CMD_ERASE_DF_SECTOR 8'h12

// commands that program or erase and so need the divider loaded
`define PROG_ERASE_MASK 32'h00060FC0
// availability per mode, unsecured then secured
`define AVAIL_UNSEC_NS 32'h0004301E
`define AVAIL_UNSEC_NX 32'h000726DE
`define AVAIL_UNSEC_SS 32'h00076FDE
`define AVAIL_UNSEC_ST 32'h00076FDE
`define AVAIL_SEC_NS 32'h000736DE
`define AVAIL_SEC_NX 32'h00000006
`define AVAIL_SEC_SS 32'h00000906
`define AVAIL_SEC_ST 32'h00000906

`endif

/* flash_launch_pkg.sv */
// Purpose: types of the launch sequencer
// Assumes: included header carries all numbers
// Notes: mode encoding matches the MODE_I pins
package flash_launch_pkg;
  typedef enum logic [1:0] {
    normal_single_chip_mode,
    normal_expanded_mode,
    special_single_chip_mode,
    special_test_mode
  } op_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CHECK,
    ST_RUN
  } seq_state_type;
endpackage : flash_launch_pkg

/* flash_launch_seq.sv */
// Purpose: APB command launch front end of the flash controller
// Assumes: mode and security state arrive as synchronous levels
// Notes: flash array does the algorithms; this block checks, launches, reports
// Notes on behaviour
// - every valid command other than 0x0D and 0x0E entered by load-then-launch while no error flag stands is started
// - while complete flag is 0, new launches and parameter writes are ignored
// - writing 1 to complete flag with no error flag set clears it and launches the loaded parameters
// - flag stays clear during command; set on completion, results in parameter fields
// - command checked against operating mode and security state
// - 0x01 verifies all program and data flash blocks erased, always available
// - 0x02 verifies one selected block erased, always available
// - 0x03 verifies a count of program flash words erased
// - 0x04 reads the 64 byte one-time field of block 0
// - 0x07 programs the one-time field, only once
// - 0x06 programs a phrase; 0x0A erases a program flash sector
// - 0x08 erases all only with all four protection open bits set
// - 0x09 erases one block; full program block needs three protection bits
// - 0x0B releases security by erase all then verify
// - 0x0C releases security when supplied keys verify
// - 0x0D sets the user margin read level
// - 0x0E sets the field margin read level, special modes only
// - 0x10, 0x11, 0x12 do data flash section verify, word program, sector erase
// - program or erase before divider written sets access error, no execution
// - invalid command code sets access error and is not processed
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`include "flash_launch_regs.svh"

module flash_launch_seq (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire flash_launch_pkg::op_mode_type MODE_I,
  input wire logic SECURED_I,
  input wire logic OTP_PROGRAMMED_I,
  output logic FLASH_START_O,
  output logic [7:0] FLASH_CMD_O,
  output logic [95:0] FLASH_ARGS_O,
  input wire logic FLASH_DONE_I,
  input wire logic FLASH_FAIL_I,
  input wire logic FLASH_RES_WE_I,
  input wire logic [2:0] FLASH_RES_IDX_I,
  input wire logic [15:0] FLASH_RES_DATA_I,
  output logic SECURITY_RELEASE_O,
  output logic [15:0] MARGIN_USER_O,
  output logic [15:0] MARGIN_FIELD_O,
  output logic BUSY_O
);
  import flash_launch_pkg::*;

  typedef struct packed {
    seq_state_type state;
    logic complete;
    logic access_err;
    logic prot_viol;
    logic verify_fail;
    logic div_loaded;
    logic [6:0] divider;
    logic [2:0] index;
    logic [`PARAM_COUNT-1:0][15:0] param;
    logic [3:0] prot;
    logic [15:0] margin_user;
    logic [15:0] margin_field;
    logic [31:0] rdata;
    logic start;
    logic release_sec;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic setup_ph;
  logic wr_acc;
  logic addr_ok;
  logic [7:0] cmd;
  logic [31:0] avail_mask;
  logic [31:0] prog_mask;
  logic avail;
  logic div_bad;
  logic prot_bad;
  logic otp_bad;
  logic local_cmd;

  // decode: writes act only at the access edge, reads are captured in setup
  always_comb begin
    setup_ph = PSEL_I && !PENABLE_I;
    wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
    if (PADDR_I == `OFS_CLOCK_DIVIDER) begin
      addr_ok = 1'b1;
    end else if (PADDR_I == `OFS_STATUS) begin
      addr_ok = 1'b1;
    end else if (PADDR_I == `OFS_PARAM_INDEX) begin
      addr_ok = 1'b1;
    end else if (PADDR_I == `OFS_PARAM_FIELD) begin
      addr_ok = 1'b1;
    end else if (PADDR_I == `OFS_PROTECTION) begin
      addr_ok = 1'b1;
    end else if (PADDR_I == `OFS_MARGIN) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // availability table lookup by mode and security
  always_comb begin
    cmd = s_q.param[0][15:8];
    // a literal cannot be indexed, so the mask goes through a variable
    prog_mask = `PROG_ERASE_MASK;
    case ({SECURED_I, MODE_I})
      {1'b0, normal_single_chip_mode}: avail_mask = `AVAIL_UNSEC_NS;
      {1'b0, normal_expanded_mode}: avail_mask = `AVAIL_UNSEC_NX;
      {1'b0, special_single_chip_mode}: avail_mask = `AVAIL_UNSEC_SS;
      {1'b0, special_test_mode}: avail_mask = `AVAIL_UNSEC_ST;
      {1'b1, normal_single_chip_mode}: avail_mask = `AVAIL_SEC_NS;
      {1'b1, normal_expanded_mode}: avail_mask = `AVAIL_SEC_NX;
      {1'b1, special_single_chip_mode}: avail_mask = `AVAIL_SEC_SS;
      default: avail_mask = `AVAIL_SEC_ST;
    endcase
    // codes above 0x1F are never valid
    avail = (cmd[7:5] == 3'h0) && avail_mask[cmd[4:0]];
    div_bad = (cmd[7:5] == 3'h0) && prog_mask[cmd[4:0]] && !s_q.div_loaded;
    otp_bad = (cmd == `CMD_PROGRAM_ONCE) && OTP_PROGRAMMED_I;
    local_cmd = (cmd == `CMD_USER_MARGIN) || (cmd == `CMD_FIELD_MARGIN);
    prot_bad = 1'b0;
    if (cmd == `CMD_ERASE_ALL) begin
      prot_bad = (s_q.prot != 4'hF);
    end else if (cmd == `CMD_ERASE_BLOCK) begin
      // data flash block needs its own open bit, program block the three others
      if (s_q.param[0][6:0] == `DF_BLOCK_GADDR) begin
        prot_bad = !s_q.prot[`PROT_DF_OPEN_BIT];
      end else begin
        prot_bad = !(s_q.prot[`PROT_LOW_DIS_BIT] && s_q.prot[`PROT_HIGH_DIS_BIT]
                     && s_q.prot[`PROT_PF_OPEN_BIT]);
      end
    end
  end

  // next-state: bus writes first, hardware events last so a set beats a clear
  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.release_sec = 1'b0;
    if (setup_ph) begin
      s_d.rdata = 32'h0000_0000;
      if (PADDR_I == `OFS_CLOCK_DIVIDER) begin
        s_d.rdata[7:0] = {s_q.div_loaded, s_q.divider};
      end else if (PADDR_I == `OFS_STATUS) begin
        s_d.rdata[`STAT_COMPLETE_BIT] = s_q.complete;
        s_d.rdata[`STAT_ACCESS_ERR_BIT] = s_q.access_err;
        s_d.rdata[`STAT_PROT_VIOL_BIT] = s_q.prot_viol;
        s_d.rdata[`STAT_VERIFY_FAIL_BIT] = s_q.verify_fail;
      end else if (PADDR_I == `OFS_PARAM_INDEX) begin
        s_d.rdata[2:0] = s_q.index;
      end else if (PADDR_I == `OFS_PARAM_FIELD) begin
        if (s_q.index < 3'(`PARAM_COUNT)) begin
          s_d.rdata[15:0] = s_q.param[s_q.index];
        end
      end else if (PADDR_I == `OFS_PROTECTION) begin
        s_d.rdata[3:0] = s_q.prot;
      end else if (PADDR_I == `OFS_MARGIN) begin
        s_d.rdata = {s_q.margin_field, s_q.margin_user};
      end
    end
    if (wr_acc) begin
      if (PADDR_I == `OFS_CLOCK_DIVIDER) begin
        s_d.divider = PWDATA_I[6:0];
        s_d.div_loaded = 1'b1;
      end else if (PADDR_I == `OFS_STATUS) begin
        // error flags are write-one-to-clear
        if (PWDATA_I[`STAT_ACCESS_ERR_BIT]) begin
          s_d.access_err = 1'b0;
        end
        if (PWDATA_I[`STAT_PROT_VIOL_BIT]) begin
          s_d.prot_viol = 1'b0;
        end
        // launch refused while busy or while an error flag stands
        if (PWDATA_I[`STAT_COMPLETE_BIT] && s_q.complete && !s_q.access_err
            && !s_q.prot_viol) begin
          s_d.complete = 1'b0;
          s_d.verify_fail = 1'b0;
          s_d.state = ST_CHECK;
        end
      end else if (PADDR_I == `OFS_PARAM_INDEX) begin
        s_d.index = PWDATA_I[2:0];
      end else if (PADDR_I == `OFS_PARAM_FIELD) begin
        if (s_q.complete && s_q.index < 3'(`PARAM_COUNT)) begin
          s_d.param[s_q.index] = PWDATA_I[15:0];
        end
      end else if (PADDR_I == `OFS_PROTECTION) begin
        s_d.prot = PWDATA_I[3:0];
      end
    end
    case (s_q.state)
      ST_IDLE: begin
      end
      ST_CHECK: begin
        if (!avail || div_bad || otp_bad) begin
          s_d.access_err = 1'b1;
          s_d.complete = 1'b1;
          s_d.state = ST_IDLE;
        end else if (prot_bad) begin
          s_d.prot_viol = 1'b1;
          s_d.complete = 1'b1;
          s_d.state = ST_IDLE;
        end else if (local_cmd) begin
          // margin levels live here, no array cycle needed
          if (cmd == `CMD_USER_MARGIN) begin
            s_d.margin_user = s_q.param[1];
          end else begin
            s_d.margin_field = s_q.param[1];
          end
          s_d.complete = 1'b1;
          s_d.state = ST_IDLE;
        end else begin
          s_d.start = 1'b1;
          s_d.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (FLASH_RES_WE_I && FLASH_RES_IDX_I < 3'(`PARAM_COUNT)) begin
          s_d.param[FLASH_RES_IDX_I] = FLASH_RES_DATA_I;
        end
        if (FLASH_DONE_I) begin
          s_d.complete = 1'b1;
          s_d.verify_fail = FLASH_FAIL_I;
          s_d.release_sec = !FLASH_FAIL_I
            && (cmd == `CMD_UNSECURE || cmd == `CMD_BACKDOOR_KEY);
          s_d.state = ST_IDLE;
        end
      end
      default: s_d.state = ST_IDLE;
    endcase
  end

  // single state register, synchronous reset
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      s_q <= '0;
      s_q.state <= ST_IDLE;
      s_q.complete <= 1'b1;
      s_q.divider <= `DIV_RESET;
      s_q.prot <= `PROT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // zero wait states; unmapped offsets answer with an error
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;
  assign PRDATA_O = s_q.rdata;
  assign FLASH_START_O = s_q.start;
  assign FLASH_CMD_O = s_q.param[0][15:8];
  assign FLASH_ARGS_O = s_q.param;
  assign SECURITY_RELEASE_O = s_q.release_sec;
  assign MARGIN_USER_O = s_q.margin_user;
  assign MARGIN_FIELD_O = s_q.margin_field;
  assign BUSY_O = !s_q.complete;

  // checks on the launch sequence
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  logic launch_wr;
  logic param_wr;
  assign launch_wr = wr_acc && PADDR_I == `OFS_STATUS && PWDATA_I[`STAT_COMPLETE_BIT];
  assign param_wr = wr_acc && PADDR_I == `OFS_PARAM_FIELD;

  property p_launch_clears;
    launch_wr && s_q.complete && !s_q.access_err && !s_q.prot_viol
      |=> !s_q.complete && s_q.state == ST_CHECK;
  endproperty
  a_launch_clears: assert property (p_launch_clears) else $error("launch did not clear flag");

  property p_busy_param_hold;
    !s_q.complete && param_wr && !FLASH_RES_WE_I |=> $stable(s_q.param);
  endproperty
  a_busy_param_hold: assert property (p_busy_param_hold) else $error("busy param write took");

  property p_busy_no_relaunch;
    s_q.state == ST_RUN && !FLASH_DONE_I |=> !s_q.complete && !s_q.start;
  endproperty
  a_busy_no_relaunch: assert property (p_busy_no_relaunch) else $error("flag set early");

  property p_done_sets;
    s_q.state == ST_RUN && FLASH_DONE_I |=> s_q.complete && s_q.state == ST_IDLE;
  endproperty
  a_done_sets: assert property (p_done_sets) else $error("completion not reported");

  property p_valid_starts;
    s_q.state == ST_CHECK && avail && !div_bad && !otp_bad && !prot_bad && !local_cmd
      |=> FLASH_START_O ##1 !FLASH_START_O;
  endproperty
  a_valid_starts: assert property (p_valid_starts) else $error("valid command not started");

  property p_unavail_err;
    s_q.state == ST_CHECK && !avail |=> s_q.access_err && s_q.complete && !FLASH_START_O;
  endproperty
  a_unavail_err: assert property (p_unavail_err) else $error("unavailable command ran");

  property p_div_err;
    s_q.state == ST_CHECK && !s_q.div_loaded && cmd == `CMD_PROGRAM_PF
      |=> s_q.access_err && !FLASH_START_O;
  endproperty
  a_div_err: assert property (p_div_err) else $error("program ran with no divider");

  property p_erase_all_prot;
    s_q.state == ST_CHECK && avail && !div_bad && cmd == `CMD_ERASE_ALL && s_q.prot != 4'hF
      |=> s_q.prot_viol && !FLASH_START_O;
  endproperty
  a_erase_all_prot: assert property (p_erase_all_prot) else $error("erase all not blocked");

  property p_field_margin_mode;
    s_q.state == ST_CHECK && cmd == `CMD_FIELD_MARGIN && !MODE_I[1]
      |=> s_q.access_err && $stable(s_q.margin_field);
  endproperty
  a_field_margin_mode: assert property (p_field_margin_mode) else $error("field margin in normal mode");

  property p_user_margin;
    s_q.state == ST_CHECK && cmd == `CMD_USER_MARGIN && avail
      |=> MARGIN_USER_O == $past(s_q.param[1]) && s_q.complete;
  endproperty
  a_user_margin: assert property (p_user_margin) else $error("user margin not set");

  property p_otp_err;
    s_q.state == ST_CHECK && avail && !div_bad && otp_bad
      |=> s_q.access_err && !FLASH_START_O;
  endproperty
  a_otp_err: assert property (p_otp_err) else $error("one-time field written twice");

  // a second launch while running must not restart the check
  property p_busy_launch_ignored;
    s_q.state == ST_RUN && launch_wr |=> s_q.state != ST_CHECK;
  endproperty
  a_busy_launch_ignored: assert property (p_busy_launch_ignored) else $error("relaunch taken");

  property p_release;
    s_q.state == ST_RUN && FLASH_DONE_I && !FLASH_FAIL_I
      && (cmd == `CMD_UNSECURE || cmd == `CMD_BACKDOOR_KEY)
      |=> SECURITY_RELEASE_O;
  endproperty
  a_release: assert property (p_release) else $error("security not released");

  property p_result_write;
    s_q.state == ST_RUN && FLASH_RES_WE_I && FLASH_RES_IDX_I == 3'h5
      |=> s_q.param[5] == $past(FLASH_RES_DATA_I);
  endproperty
  a_result_write: assert property (p_result_write) else $error("result not stored");

  property p_pf_block_prot;
    s_q.state == ST_CHECK && avail && !div_bad && cmd == `CMD_ERASE_BLOCK
      && s_q.param[0][6:0] != `DF_BLOCK_GADDR
      && !(s_q.prot[`PROT_LOW_DIS_BIT] && s_q.prot[`PROT_HIGH_DIS_BIT]
           && s_q.prot[`PROT_PF_OPEN_BIT])
      |=> s_q.prot_viol && !FLASH_START_O;
  endproperty
  a_pf_block_prot: assert property (p_pf_block_prot) else $error("block erase not blocked");

  c_launch: cover property (s_q.state == ST_CHECK ##1 FLASH_START_O);
  c_complete: cover property (s_q.state == ST_RUN ##1 FLASH_DONE_I ##1 s_q.complete);
  c_access_err: cover property (s_q.state == ST_CHECK ##1 s_q.access_err);
  c_release: cover property (SECURITY_RELEASE_O);
  c_prot_viol: cover property (s_q.state == ST_CHECK ##1 s_q.prot_viol);
endmodule : flash_launch_seq

/* flash_array_model.sv */
// Purpose: behavioural flash array behind the launch sequencer
// Assumes: one start pulse per command, answer after a set delay
// Notes: idle result lines toggle so stale values never look valid
`timescale 1ns/1ns
module flash_array_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [7:0] cmd_i,
  input wire logic [31:0] delay_i,
  input wire logic fail_req_i,
  output logic done_o,
  output logic fail_o,
  output logic res_we_o,
  output logic [2:0] res_idx_o,
  output logic [15:0] res_data_o,
  output int starts_o
);
  int cnt = 0;
  logic tog = 1'b0;
  logic [7:0] cmd_q = 8'h00;
  initial begin
    done_o = 1'b0;
    res_we_o = 1'b0;
    starts_o = 0;
  end
  // count one command down; the result lands one cycle before done
  always @(posedge clk_i) begin
    tog <= ~tog;
    done_o <= 1'b0;
    res_we_o <= 1'b0;
    if (start_i === 1'b1) begin
      starts_o <= starts_o + 1;
      cmd_q <= cmd_i;
      cnt <= (delay_i < 2) ? 2 : delay_i;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      res_we_o <= (cnt == 2);
      done_o <= (cnt == 1);
    end
  end
  // fail and result lines mean something only with their strobes
  assign fail_o = done_o ? fail_req_i : tog;
  assign res_idx_o = res_we_o ? 3'h5 : {3{tog}};
  assign res_data_o = res_we_o ? {8'hC3, cmd_q} : {16{tog}};
endmodule : flash_array_model

/* testbench.sv */
// Purpose: self-checking bench of the flash command launch sequencer
// Assumes: APB slave answers without wait states, array model behind it
// Notes: mode table is rebuilt here by hand, one bit per command code
`timescale 1ns/1ns
`include "flash_launch_regs.svh"
module testbench;
  import flash_launch_pkg::*;
  logic clk;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, last_err, sec, otp, fail_req, start, done, fail, res_we, rel, busy;
  op_mode_type mode = normal_single_chip_mode;
  logic [7:0] cmd;
  logic [95:0] args;
  logic [2:0] res_idx;
  logic [15:0] res_data, mu, mf;
  int dly = 3;
  int starts, rel_cnt = 0, error_cnt = 0, check_count = 0;
  initial begin
    sec = 1'b0;
    otp = 1'b0;
    fail_req = 1'b0;
  end
  flash_launch_seq dut_u (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .MODE_I(mode), .SECURED_I(sec),
    .OTP_PROGRAMMED_I(otp), .FLASH_START_O(start), .FLASH_CMD_O(cmd), .FLASH_ARGS_O(args),
    .FLASH_DONE_I(done), .FLASH_FAIL_I(fail), .FLASH_RES_WE_I(res_we),
    .FLASH_RES_IDX_I(res_idx), .FLASH_RES_DATA_I(res_data), .SECURITY_RELEASE_O(rel),
    .MARGIN_USER_O(mu), .MARGIN_FIELD_O(mf), .BUSY_O(busy));
  flash_array_model array_u (.clk_i(clk), .start_i(start), .cmd_i(cmd), .delay_i(dly),
    .fail_req_i(fail_req), .done_o(done), .fail_o(fail), .res_we_o(res_we),
    .res_idx_o(res_idx), .res_data_o(res_data), .starts_o(starts));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // release pulses are counted so a missing or doubled one shows
  always @(posedge clk) if (rel === 1'b1) rel_cnt <= rel_cnt + 1;
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // one APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      error_cnt++;
      summarize();
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic load(input logic [7:0] c, input logic [6:0] ga);
    wr(`OFS_PARAM_INDEX, 32'h0);
    wr(`OFS_PARAM_FIELD, {16'h0, c, 1'b0, ga});
  endtask : load
  // launch one command, wait for completion, judge start, errors and result
  task automatic go(input logic [7:0] c, input logic [6:0] ga, input logic es,
                    input logic [1:0] ee, input string m);
    int i, n0, nb;
    logic [31:0] r;
    load(c, ga);
    n0 = starts;
    nb = 0;
    wr(`OFS_STATUS, 32'h80);
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (busy !== 1'b1) break;
      nb++;
    end
    if (i == 300) begin
      error_cnt++;
      summarize();
    end
    chk(32'(starts - n0), {31'h0, es}, m);
    apb(1'b0, `OFS_STATUS, 32'h0, r);
    chk({30'h0, r[5:4]}, {30'h0, ee}, m);
    if (es) begin
      chk({31'h0, nb >= dly}, 32'h1, m);
      wr(`OFS_PARAM_INDEX, 32'h5);
      apb(1'b0, `OFS_PARAM_FIELD, 32'h0, r);
      chk(r, {16'h0, 8'hC3, c}, m);
    end
    wr(`OFS_STATUS, 32'h30);
  endtask : go
  task automatic reset_values();
    logic [31:0] r;
    apb(1'b0, `OFS_STATUS, 32'h0, r);
    chk(r, 32'h80, "status reset");
    apb(1'b0, `OFS_CLOCK_DIVIDER, 32'h0, r);
    chk(r, 32'h0, "divider reset");
    apb(1'b0, 8'h18, 32'h0, r);
    chk({31'h0, last_err}, 32'h1, "unmapped");
  endtask : reset_values
  task automatic divider();
    logic [31:0] r;
    mode <= normal_expanded_mode;
    go(`CMD_PROGRAM_PF, 7'h00, 1'b0, 2'b10, "no divider");
    go(`CMD_VERIFY_ALL, 7'h00, 1'b1, 2'b00, "verify w/o divider");
    wr(`OFS_CLOCK_DIVIDER, 32'h0F);
    apb(1'b0, `OFS_CLOCK_DIVIDER, 32'h0, r);
    chk(r, 32'h8F, "divider loaded");
  endtask : divider
  // writes during a running command must not disturb it
  task automatic busy_block();
    logic [31:0] r;
    int n0, i;
    dly = 40;
    load(`CMD_VERIFY_BLOCK, 7'h00);
    wr(`OFS_PARAM_INDEX, 32'h1);
    wr(`OFS_PARAM_FIELD, 32'h1234);
    n0 = starts;
    wr(`OFS_STATUS, 32'h80);
    apb(1'b0, `OFS_STATUS, 32'h0, r);
    chk({31'h0, r[7]}, 32'h0, "flag clear while busy");
    wr(`OFS_PARAM_FIELD, 32'hFFFF);
    wr(`OFS_STATUS, 32'h80);
    for (i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk);
    if (i == 300) begin
      error_cnt++;
      summarize();
    end
    chk(32'(starts - n0), 32'h1, "single start");
    chk({16'h0, args[31:16]}, 32'h1234, "args pins");
    wr(`OFS_PARAM_INDEX, 32'h1);
    apb(1'b0, `OFS_PARAM_FIELD, 32'h0, r);
    chk(r, 32'h1234, "param kept");
    dly = 3;
  endtask : busy_block
  task automatic error_blocks();
    int n0;
    load(8'h05, 7'h00);
    wr(`OFS_STATUS, 32'h80);
    repeat (4) @(posedge clk);
    n0 = starts;
    load(`CMD_VERIFY_ALL, 7'h00);
    wr(`OFS_STATUS, 32'h80);
    repeat (6) @(posedge clk);
    chk(32'(starts - n0), 32'h0, "launch with error set");
    wr(`OFS_STATUS, 32'h30);
  endtask : error_blocks
  task automatic mode_table();
    logic [31:0] av [8];
    int m, c;
    av = '{32'h0004301E, 32'h000726DE, 32'h00076FDE, 32'h00076FDE,
           32'h000736DE, 32'h00000006, 32'h00000906, 32'h00000906};
    wr(`OFS_PROTECTION, 32'hF);
    for (m = 0; m < 8; m++) begin
      mode <= op_mode_type'(m[1:0]);
      sec <= m[2];
      for (c = 0; c < 19; c++)
        go(8'(c), 7'h00, av[m][c] && c != 13 && c != 14, av[m][c] ? 2'b00 : 2'b10,
           "mode table");
    end
    sec <= 1'b0;
  endtask : mode_table
  task automatic protect_otp_margin();
    logic [31:0] r;
    mode <= special_single_chip_mode;
    wr(`OFS_PROTECTION, 32'h7);
    go(`CMD_ERASE_ALL, 7'h00, 1'b0, 2'b01, "erase all guarded");
    wr(`OFS_PROTECTION, 32'h8);
    go(`CMD_ERASE_BLOCK, 7'h00, 1'b0, 2'b01, "pf block guarded");
    go(`CMD_ERASE_BLOCK, `DF_BLOCK_GADDR, 1'b1, 2'b00, "df block");
    otp <= 1'b1;
    go(`CMD_PROGRAM_ONCE, 7'h00, 1'b0, 2'b10, "once used");
    otp <= 1'b0;
    wr(`OFS_PARAM_INDEX, 32'h1);
    wr(`OFS_PARAM_FIELD, 32'h0055);
    go(`CMD_FIELD_MARGIN, 7'h00, 1'b0, 2'b00, "field margin");
    wr(`OFS_PARAM_INDEX, 32'h1);
    wr(`OFS_PARAM_FIELD, 32'h00AA);
    go(`CMD_USER_MARGIN, 7'h00, 1'b0, 2'b00, "user margin");
    apb(1'b0, `OFS_MARGIN, 32'h0, r);
    chk(r, 32'h005500AA, "margins");
    chk({mf, mu}, 32'h005500AA, "margin pins");
  endtask : protect_otp_margin
  task automatic security();
    logic [31:0] r;
    int n0;
    mode <= normal_single_chip_mode;
    sec <= 1'b1;
    fail_req <= 1'b1;
    n0 = rel_cnt;
    go(`CMD_BACKDOOR_KEY, 7'h00, 1'b1, 2'b00, "bad keys");
    apb(1'b0, `OFS_STATUS, 32'h0, r);
    chk({31'h0, r[0]}, 32'h1, "verify fail flag");
    fail_req <= 1'b0;
    go(`CMD_BACKDOOR_KEY, 7'h00, 1'b1, 2'b00, "good keys");
    mode <= special_test_mode;
    go(`CMD_UNSECURE, 7'h00, 1'b1, 2'b00, "unsecure");
    chk(32'(rel_cnt - n0), 32'h2, "release pulses");
  endtask : security
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    reset_values();
    divider();
    busy_block();
    error_blocks();
    mode_table();
    protect_otp_margin();
    security();
    summarize();
  end
endmodule : testbench
